// *** hdl/icr_defines.vh ***
// constants for the io cell control and routing block
`ifndef ICR_DEFINES_VH
`define ICR_DEFINES_VH

// array sizes
`define ICR_NUM_CELLS 8
`define ICR_BUS_LINES 12
`define ICR_DED_INPUTS 6
`define ICR_DED_CLOCKS 2
`define ICR_NUM_GLOBALS 4
`define ICR_ROW_CH 144
`define ICR_ROW_REACH 18
`define ICR_COL_CH 24
`define ICR_COL_REACH 16

// peripheral control line positions
`define ICR_LINE_OUT_EN_0 0
`define ICR_LINE_CLK_EN_0 6
`define ICR_LINE_CLOCK_0 6
`define ICR_LINE_OUT_EN_6 7
`define ICR_LINE_CLEAR_0 8
`define ICR_LINE_OUT_EN_7 9
`define ICR_LINE_CLEAR_1 10
`define ICR_LINE_CLOCK_1 11
`define ICR_GLOBAL_LINE_0 6
`define ICR_GLOBAL_LINE_1 7
`define ICR_GLOBAL_LINE_2 9
`define ICR_GLOBAL_LINE_3 11

// line source select codes, below 6 a dedicated input
`define ICR_SRC_LOGIC_ELEMENT 4'h6
`define ICR_SRC_COLUMN_RELAY 4'h7

// cell clock select codes
`define ICR_CLK_PERIPH_0 2'h0
`define ICR_CLK_PERIPH_1 2'h1
`define ICR_CLK_DEDICATED_0 2'h2
`define ICR_CLK_DEDICATED_1 2'h3

// cell clock enable select codes, below 6 a bus clock enable
`define ICR_CE_LOGIC_ELEMENT 3'h6
`define ICR_CE_ALWAYS 3'h7

// cell clear select codes
`define ICR_CLR_NONE 2'h0
`define ICR_CLR_PERIPH_0 2'h1
`define ICR_CLR_PERIPH_1 2'h2

// cell output enable select codes, below 6 a bus output enable
`define ICR_OE_PERIPH_6 4'h6
`define ICR_OE_PERIPH_7 4'h7
`define ICR_OE_LOGIC_ELEMENT 4'h8
`define ICR_OE_ALWAYS 4'h9

// reset values
`define ICR_REG_RESET 1'b0
`define ICR_LINE_RESET 12'h000
`define ICR_GLOBAL_RESET 4'h0
`define ICR_DRIVE_RESET 16'h0000
`define ICR_PAD_RESET 8'h00
`define ICR_PIN_OE_N_RESET 8'hFF

`endif

// *** hdl/icr_periph_bus.v ***
// peripheral control bus source selection and global net drive
`timescale 1ns/1ns
`default_nettype none
`include "icr_defines.vh"

module icr_periph_bus (
    // clock and reset
    input wire clock,
    input wire reset,
    // sources
    input wire [5:0] dedInput,
    input wire [11:0] lineLeDrive,
    input wire [11:0] lineColRelay,
    input wire [47:0] lineSrcSel,
    input wire [3:0] globalInternal,
    // results
    output reg [11:0] periphLine,
    output reg [3:0] globalNet
);

    reg [11:0] next_periphLine;
    reg [3:0] next_globalNet;
    reg [3:0] sel;
    integer i;

    // per line source mux
    always @* begin
        sel = 4'h0;
        next_periphLine = `ICR_LINE_RESET;
        for (i = 0; i < `ICR_BUS_LINES; i = i + 1) begin
            sel = lineSrcSel[4*i +: 4];
            if (sel < 4'h6) begin
                next_periphLine[i] = dedInput[sel[2:0]];
            end else if (sel == `ICR_SRC_LOGIC_ELEMENT) begin
                next_periphLine[i] = lineLeDrive[i];
            end else if (sel == `ICR_SRC_COLUMN_RELAY) begin
                next_periphLine[i] = lineColRelay[i];
            end else begin
                next_periphLine[i] = 1'b0;
            end
        end
    end

    // globals take a bus line or their own dedicated pin
    always @* begin
        next_globalNet[0] = globalInternal[0] ? next_periphLine[`ICR_GLOBAL_LINE_0] : dedInput[0];
        next_globalNet[1] = globalInternal[1] ? next_periphLine[`ICR_GLOBAL_LINE_1] : dedInput[1];
        next_globalNet[2] = globalInternal[2] ? next_periphLine[`ICR_GLOBAL_LINE_2] : dedInput[2];
        next_globalNet[3] = globalInternal[3] ? next_periphLine[`ICR_GLOBAL_LINE_3] : dedInput[3];
    end

    // registered bus and globals, pin ignored when internal
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            periphLine <= `ICR_LINE_RESET;
            globalNet <= `ICR_GLOBAL_RESET;
        end else begin
            periphLine <= next_periphLine;
            globalNet <= next_globalNet;
        end
    end

endmodule
`default_nettype wire

// *** hdl/icr_io_cell.v ***
// one io cell: control selection, register and data multiplexers
`timescale 1ns/1ns
`default_nettype none
`include "icr_defines.vh"

module icr_io_cell (
    // clock and reset
    input wire clock,
    input wire reset,
    input wire chipClrN,
    // control sources
    input wire [11:0] periphLine,
    input wire [1:0] dedClock,
    input wire leClkEn,
    input wire leOutEn,
    // configuration
    input wire [1:0] clkSel,
    input wire [2:0] clkEnSel,
    input wire [1:0] clrSel,
    input wire [3:0] oeSel,
    input wire isOutput,
    input wire useReg,
    input wire fromCol,
    input wire [4:0] rowSel,
    input wire [3:0] colSel,
    // data
    input wire [17:0] rowTaps,
    input wire [15:0] colTaps,
    input wire padIn,
    output wire dataOut,
    output wire outEn,
    output reg cellReg
);

    reg clkSrc;
    reg clkPrev;
    reg clkEn;
    reg clr;
    reg oe;
    wire clkEdge;
    wire rowPick;
    wire dIn;

    // one clock source at a time, edge found against last sample
    always @* begin
        case (clkSel)
            `ICR_CLK_PERIPH_0: clkSrc = periphLine[`ICR_LINE_CLOCK_0];
            `ICR_CLK_PERIPH_1: clkSrc = periphLine[`ICR_LINE_CLOCK_1];
            `ICR_CLK_DEDICATED_0: clkSrc = dedClock[0];
            default: clkSrc = dedClock[1];
        endcase
    end
    assign clkEdge = clkSrc & ~clkPrev;

    // clock enable, clear and output enable selection
    always @* begin
        if (clkEnSel < 3'h6) begin
            clkEn = periphLine[`ICR_LINE_CLK_EN_0 + clkEnSel];
        end else if (clkEnSel == `ICR_CE_LOGIC_ELEMENT) begin
            clkEn = leClkEn;
        end else begin
            clkEn = 1'b1;
        end
        case (clrSel)
            `ICR_CLR_PERIPH_0: clr = periphLine[`ICR_LINE_CLEAR_0];
            `ICR_CLR_PERIPH_1: clr = periphLine[`ICR_LINE_CLEAR_1];
            default: clr = 1'b0;
        endcase
        if (oeSel < 4'h6) begin
            oe = periphLine[oeSel];
        end else if (oeSel == `ICR_OE_PERIPH_6) begin
            oe = periphLine[`ICR_LINE_OUT_EN_6];
        end else if (oeSel == `ICR_OE_PERIPH_7) begin
            oe = periphLine[`ICR_LINE_OUT_EN_7];
        end else if (oeSel == `ICR_OE_LOGIC_ELEMENT) begin
            oe = leOutEn;
        end else begin
            oe = (oeSel == `ICR_OE_ALWAYS);
        end
    end

    // output data from a row or a column channel
    assign rowPick = (rowSel < 5'd18) ? rowTaps[rowSel] : 1'b0;
    assign dIn = isOutput ? (fromCol ? colTaps[colSel] : rowPick) : padIn;
    assign dataOut = useReg ? cellReg : dIn;
    assign outEn = isOutput & oe;

    // cell register, chip-wide clear first
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            cellReg <= `ICR_REG_RESET;
            clkPrev <= 1'b0;
        end else begin
            clkPrev <= clkSrc;
            if (!chipClrN) begin
                cellReg <= `ICR_REG_RESET;
            end else if (clr) begin
                cellReg <= `ICR_REG_RESET;
            end else if (clkEdge && clkEn) begin
                cellReg <= dIn;
            end
        end
    end

endmodule
`default_nettype wire

// *** hdl/icr_io_control.v ***
// top of the io cell control and routing block
`timescale 1ns/1ns
`default_nettype none
`include "icr_defines.vh"

module icr_io_control (
    // clock and reset
    input wire clock,
    input wire reset,
    // chip-wide pins
    input wire chipClrN,
    input wire chipOeN,
    input wire chipOeOption,
    // dedicated pins
    input wire [5:0] dedInput,
    input wire [1:0] dedClock,
    // bus line sources
    input wire [47:0] lineSrcSel,
    input wire [11:0] lineLeDrive,
    input wire [11:0] lineColRelay,
    input wire [3:0] globalInternal,
    // controls from logic elements
    input wire [7:0] leClkEn,
    input wire [7:0] leOutEn,
    // cell configuration
    input wire [7:0] cellIsOutput,
    input wire [7:0] cellUseReg,
    input wire [7:0] cellFromCol,
    input wire [15:0] cellClkSel,
    input wire [23:0] cellClkEnSel,
    input wire [15:0] cellClrSel,
    input wire [31:0] cellOeSel,
    input wire [39:0] cellRowSel,
    input wire [31:0] cellColSel,
    // routing channels
    input wire [143:0] rowChannel,
    input wire [23:0] colChannel,
    output reg [15:0] rowDrive,
    output reg [15:0] colDrive,
    // pins
    input wire [7:0] padIn,
    output reg [7:0] padOut,
    output reg [7:0] padOutEnN,
    // status
    output wire [11:0] periphLine,
    output wire [3:0] globalNet,
    output wire [7:0] cellState
);

    wire [7:0] cellData;
    wire [7:0] cellOutEn;
    wire floatAll;
    reg [15:0] next_rowDrive;
    reg [15:0] next_colDrive;
    integer c;

    // --------------------------------------------------------------
    // peripheral control bus
    // --------------------------------------------------------------

    icr_periph_bus u_bus (
        .clock(clock),
        .reset(reset),
        .dedInput(dedInput),
        .lineLeDrive(lineLeDrive),
        .lineColRelay(lineColRelay),
        .lineSrcSel(lineSrcSel),
        .globalInternal(globalInternal),
        .periphLine(periphLine),
        .globalNet(globalNet)
    );

    // --------------------------------------------------------------
    // io cells
    // --------------------------------------------------------------

    genvar i;
    genvar k;
    generate
        for (i = 0; i < `ICR_NUM_CELLS; i = i + 1) begin : g_cell
            wire [15:0] colTaps;
            // distinct column window per cell, channels i to i+15, never wrapping
            for (k = 0; k < `ICR_COL_REACH; k = k + 1) begin : g_tap
                assign colTaps[k] = colChannel[(i + k) % `ICR_COL_CH];
            end
            icr_io_cell u_cell (
                .clock(clock),
                .reset(reset),
                .chipClrN(chipClrN),
                .periphLine(periphLine),
                .dedClock(dedClock),
                .leClkEn(leClkEn[i]),
                .leOutEn(leOutEn[i]),
                .clkSel(cellClkSel[2*i +: 2]),
                .clkEnSel(cellClkEnSel[3*i +: 3]),
                .clrSel(cellClrSel[2*i +: 2]),
                .oeSel(cellOeSel[4*i +: 4]),
                .isOutput(cellIsOutput[i]),
                .useReg(cellUseReg[i]),
                .fromCol(cellFromCol[i]),
                .rowSel(cellRowSel[5*i +: 5]),
                .colSel(cellColSel[4*i +: 4]),
                .rowTaps(rowChannel[`ICR_ROW_REACH*i +: `ICR_ROW_REACH]),
                .colTaps(colTaps),
                .padIn(padIn[i]),
                .dataOut(cellData[i]),
                .outEn(cellOutEn[i]),
                .cellReg(cellState[i])
            );
        end
    endgenerate

    // --------------------------------------------------------------
    // channel drive and pins
    // --------------------------------------------------------------

    assign floatAll = chipOeOption & ~chipOeN;

    // input cells drive their two row and two column channels
    always @* begin
        next_rowDrive = 16'h0000;
        next_colDrive = 16'h0000;
        for (c = 0; c < `ICR_NUM_CELLS; c = c + 1) begin
            if (!cellIsOutput[c]) begin
                next_rowDrive[2*c] = cellData[c];
                next_rowDrive[2*c+1] = cellData[c];
                next_colDrive[2*c] = cellData[c];
                next_colDrive[2*c+1] = cellData[c];
            end
        end
    end

    // registered outputs, enables low while driving
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            rowDrive <= `ICR_DRIVE_RESET;
            colDrive <= `ICR_DRIVE_RESET;
            padOut <= `ICR_PAD_RESET;
            padOutEnN <= `ICR_PIN_OE_N_RESET;
        end else begin
            rowDrive <= next_rowDrive;
            colDrive <= next_colDrive;
            padOut <= cellData;
            padOutEnN <= ~(cellOutEn & {8{~floatAll}});
        end
    end

endmodule
`default_nettype wire

// *** test/icr_io_control_properties.sv ***
// checker for the io cell control and routing block
`timescale 1ns/1ns
`default_nettype none
module icr_io_control_properties (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // inputs watched
    input wire logic chipClrN,
    input wire logic chipOeN,
    input wire logic chipOeOption,
    input wire logic [5:0] dedInput,
    input wire logic [47:0] lineSrcSel,
    input wire logic [11:0] lineLeDrive,
    input wire logic [11:0] lineColRelay,
    input wire logic [3:0] globalInternal,
    input wire logic [7:0] cellIsOutput,
    input wire logic [7:0] cellUseReg,
    input wire logic [7:0] padIn,
    // outputs watched
    input wire logic [15:0] rowDrive,
    input wire logic [15:0] colDrive,
    input wire logic [7:0] padOutEnN,
    input wire logic [11:0] periphLine,
    input wire logic [3:0] globalNet,
    input wire logic [7:0] cellState
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // ----
    // chip-wide pins
    // ----
    a_chip_clear_wins: assert property (!chipClrN |=> cellState == 8'h00)
        else $error("cell registers not cleared");
    a_float_all_pins: assert property ((chipOeOption && !chipOeN) [*2] |-> padOutEnN == 8'hFF)
        else $error("pins not floated");
    // ----
    // bus lines and globals
    // ----
    a_line_from_pin: assert property (lineSrcSel[3:0] < 4'h6 |=> periphLine[0] == $past(dedInput[lineSrcSel[3:0]]))
        else $error("line 0 not from dedicated pin");
    a_line_from_le: assert property (lineSrcSel[27:24] == 4'h6 |=> periphLine[6] == $past(lineLeDrive[6]))
        else $error("line 6 not from logic element");
    a_line_relay: assert property (lineSrcSel[47:44] == 4'h7 |=> periphLine[11] == $past(lineColRelay[11]))
        else $error("line 11 not from column relay");
    a_global_from_pin: assert property (!globalInternal[1] |=> globalNet[1] == $past(dedInput[1]))
        else $error("global 1 not from its pin");
    // ----
    // routing
    // ----
    a_row_drive_pair: assert property (!cellIsOutput[2] && !cellUseReg[2] |=> rowDrive[5:4] == {2{$past(padIn[2])}})
        else $error("input cell row pair wrong");
    a_col_drive_pair: assert property (!cellIsOutput[2] && !cellUseReg[2] |=> colDrive[5:4] == {2{$past(padIn[2])}})
        else $error("input cell column pair wrong");
    a_output_no_drive: assert property (cellIsOutput[3] |=> rowDrive[7:6] == 2'h0 && colDrive[7:6] == 2'h0)
        else $error("output cell drives channels");
    // main scenarios seen
    c_float: cover property (chipOeOption && !chipOeN);
    c_clear: cover property (!chipClrN ##1 chipClrN);
    c_capture: cover property ($rose(cellState[0]));
endmodule
bind icr_io_control icr_io_control_properties u_props (.clock, .reset, .chipClrN, .chipOeN,
    .chipOeOption, .dedInput, .lineSrcSel, .lineLeDrive, .lineColRelay, .globalInternal,
    .cellIsOutput, .cellUseReg, .padIn, .rowDrive, .colDrive, .padOutEnN, .periphLine,
    .globalNet, .cellState);
`default_nettype wire

// *** test/icr_fabric_model.sv ***
// model of the logic array and routing channels beside the io cells
`timescale 1ns/1ns
`default_nettype none
module icr_fabric_model (
    // clock
    input wire logic clock,
    // bench settings
    input wire logic [7:0] pattern,
    input wire logic [5:0] pinLevel,
    input wire logic [3:0] globalInternal,
    // drive into the io cells
    output logic [143:0] rowChannel = 144'h0,
    output logic [23:0] colChannel = 24'h0,
    output logic [11:0] lineLeDrive = 12'h0,
    output logic [11:0] lineColRelay = 12'h0,
    output logic [5:0] dedInput = 6'h0
);
    // channels and logic elements change off the sampling edge
    always @(negedge clock) begin
        rowChannel <= {18{pattern}};
        colChannel <= {3{~pattern}};
        lineLeDrive <= {pattern[3:0], pattern};
        lineColRelay <= ~{pattern[3:0], pattern};
        dedInput <= pinLevel & ~{2'h0, globalInternal};
    end
endmodule
`default_nettype wire

// *** test/tb.sv ***
// bench for the io cell control and routing block
`timescale 1ns/1ns
`default_nettype none
module tb;
    // ----
    // stimulus and results
    // ----
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic chipClrN = 1'b1;
    logic chipOeN = 1'b1;
    logic chipOeOption = 1'b0;
    logic [1:0] dedClock = 2'h0;
    logic [47:0] lineSrcSel = 48'h0;
    logic [3:0] globalInternal = 4'h0;
    logic [7:0] leClkEn = 8'h00, leOutEn = 8'h00, padIn = 8'h00;
    logic [7:0] cellIsOutput = 8'h00, cellUseReg = 8'h00, cellFromCol = 8'h00;
    logic [15:0] cellClkSel = 16'h0, cellClrSel = 16'h0;
    logic [23:0] cellClkEnSel = 24'h0;
    logic [31:0] cellOeSel = 32'h0, cellColSel = 32'h0;
    logic [39:0] cellRowSel = 40'h0;
    wire [143:0] rowChannel;
    wire [23:0] colChannel;
    wire [11:0] lineLeDrive, lineColRelay, periphLine;
    wire [5:0] dedInput;
    wire [15:0] rowDrive, colDrive;
    wire [7:0] padOut, padOutEnN, cellState;
    wire [3:0] globalNet;
    integer failures = 0;
    integer checks = 0;
    // ----
    // instances
    // ----
    icr_io_control u_dut (.clock, .reset, .chipClrN, .chipOeN, .chipOeOption, .dedInput,
        .dedClock, .lineSrcSel, .lineLeDrive, .lineColRelay, .globalInternal, .leClkEn,
        .leOutEn, .cellIsOutput, .cellUseReg, .cellFromCol, .cellClkSel, .cellClkEnSel,
        .cellClrSel, .cellOeSel, .cellRowSel, .cellColSel, .rowChannel, .colChannel,
        .rowDrive, .colDrive, .padIn, .padOut, .padOutEnN, .periphLine, .globalNet,
        .cellState);
    icr_fabric_model u_fabric (.clock, .pattern(8'hA5), .pinLevel(6'h2A), .globalInternal,
        .rowChannel, .colChannel, .lineLeDrive, .lineColRelay, .dedInput);
    // 100 MHz clock
    initial begin
        forever #5 clock = ~clock;
    end
    // ----
    // helpers
    // ----
    task step(input integer n);
        repeat (n) @(negedge clock);
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("unexpected at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // one high pulse on a dedicated clock pin
    task pulse(input integer n);
        begin
            dedClock[n] = 1'b1;
            step(2);
            dedClock[n] = 1'b0;
            step(2);
        end
    endtask
    task conclude;
        begin
            $display("checks %0d failures %0d", checks, failures);
            if (failures == 0 && checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // ----
    // scenarios
    // ----
    // every line source code, then globals from lines and pins
    task t_lines;
        integer i;
        begin
            lineSrcSel = {12{4'h6}};
            step(3);
            chk(periphLine, lineLeDrive);
            lineSrcSel = {12{4'h7}};
            step(3);
            chk(periphLine, lineColRelay);
            for (i = 0; i < 6; i = i + 1) begin
                lineSrcSel = {12{i[3:0]}};
                step(3);
                chk(periphLine, {12{dedInput[i]}});
            end
            globalInternal = 4'hF;
            step(3);
            chk(globalNet, 4'hF);
            globalInternal = 4'h0;
            step(3);
            chk(globalNet, 4'hA);
            $display("lines test done");
        end
    endtask
    // input cells drive channel pairs, output cells read row and column muxes
    task t_route;
        integer i;
        logic [15:0] d;
        logic [7:0] e;
        begin
            padIn = 8'h96;
            step(3);
            for (i = 0; i < 8; i = i + 1)
                d[2*i+:2] = {2{padIn[i]}};
            chk(rowDrive, d);
            chk(colDrive, d);
            cellIsOutput = 8'hFF;
            leOutEn = 8'hFF;
            cellOeSel = 32'h99999989;
            for (i = 0; i < 8; i = i + 1) begin
                cellRowSel[5*i+:5] = i[4:0];
                cellColSel[4*i+:4] = 2 * i[3:0];
            end
            step(3);
            for (i = 0; i < 8; i = i + 1)
                e[i] = rowChannel[19*i];
            chk(padOut, e);
            chk(padOutEnN, 8'h00);
            chk(rowDrive, 16'h0);
            cellFromCol = 8'hFF;
            step(3);
            for (i = 0; i < 8; i = i + 1)
                e[i] = colChannel[3*i];
            chk(padOut, e);
            $display("route test done");
        end
    endtask
    // chip-wide float only with the option set
    task t_float;
        begin
            chipOeOption = 1'b1;
            chipOeN = 1'b0;
            step(3);
            chk(padOutEnN, 8'hFF);
            chipOeOption = 1'b0;
            step(3);
            chk(padOutEnN, 8'h00);
            chipOeN = 1'b1;
            $display("float test done");
        end
    endtask
    // register capture, chip clear, enables and clock choice
    task t_reg;
        begin
            cellIsOutput = 8'h00;
            cellUseReg = 8'hFF;
            cellClkSel = 16'hAAAA;
            cellClkEnSel = {8{3'h7}};
            padIn = 8'hFF;
            // let the new clock source settle low before its first edge
            step(2);
            pulse(0);
            chk(cellState, 8'hFF);
            chipClrN = 1'b0;
            step(2);
            chk(cellState, 8'h00);
            pulse(0);
            chk(cellState, 8'h00);
            chipClrN = 1'b1;
            cellClkEnSel = {8{3'h6}};
            leClkEn = 8'h0F;
            pulse(0);
            chk(cellState, 8'h0F);
            padIn = 8'h00;
            cellClkSel = 16'hFFFF;
            cellClkEnSel = {8{3'h7}};
            pulse(0);
            chk(cellState, 8'h0F);
            pulse(1);
            chk(cellState, 8'h00);
            $display("register test done");
        end
    endtask
    // bus clocks, bus clears, bus clock enables and bus output enables
    task t_bus;
        begin
            lineSrcSel = 48'h000000000000;
            padIn = 8'hFF;
            step(3);
            cellClkSel = 16'h4444;
            step(2);
            chk(cellState, 8'h00);
            lineSrcSel = 48'h100001000000;
            step(3);
            chk(cellState, 8'hFF);
            cellClrSel = 16'h6666;
            lineSrcSel = 48'h110101000000;
            step(3);
            chk(cellState, 8'h00);
            cellClrSel = 16'h0000;
            cellClkEnSel = {8{3'h2}};
            lineSrcSel = 48'h000000000000;
            step(3);
            lineSrcSel = 48'h100001000000;
            step(3);
            chk(cellState, 8'h00);
            lineSrcSel = 48'h000100000000;
            step(3);
            lineSrcSel = 48'h100101000000;
            step(3);
            chk(cellState, 8'hFF);
            cellIsOutput = 8'hFF;
            cellOeSel = 32'h76543210;
            lineSrcSel = 48'h000000000000;
            step(3);
            chk(padOutEnN, 8'hFF);
            lineSrcSel = {12{4'h1}};
            step(3);
            chk(padOutEnN, 8'h00);
            $display("bus test done");
        end
    endtask
    // main sequence
    initial begin
        step(20);
        reset = 1'b0;
        step(2);
        t_lines;
        t_route;
        t_float;
        t_reg;
        t_bus;
        conclude;
    end
    // watchdog
    initial begin
        #20000;
        failures = failures + 1;
        $display("watchdog expired");
        conclude;
    end
endmodule
`default_nettype wire
